// [baud_gen_defs.svh]
`ifndef BAUD_GEN_DEFS_SVH
`define BAUD_GEN_DEFS_SVH
// Register byte addresses on the APB bus
`define ADDR_RECEIVE_STATUS_CONTROL 12'h000
`define ADDR_BAUD_DIVISOR 12'h004
`define ADDR_TRANSMIT_STATUS_CONTROL 12'h008
`define ADDR_GEN_STATUS 12'h00c
// Field positions
`define TXSC_SYNC_BIT 4
`define TXSC_HIGH_SPEED_BIT 2
`define RCSC_ENABLE_BIT 7
// Reset values
`define RESET_RECEIVE_STATUS_CONTROL 8'h00
`define RESET_BAUD_DIVISOR 8'h00
`define RESET_TRANSMIT_STATUS_CONTROL 8'h02
// Writable masks: bit 3 of transmit control is unimplemented
`define MASK_TRANSMIT_STATUS_CONTROL 8'hf7
// Prescale counts
`define PRESCALE_ASYNC_LOW 7'h40
`define PRESCALE_ASYNC_HIGH 7'h10
`define PRESCALE_SYNC 7'h04
`endif

// [baud_gen_pkg.sv]
package baud_gen_pkg;
  // Operating rate selection
  typedef enum logic [2:0] {
    RATE_ASYNC_LOW = 3'b001,
    RATE_ASYNC_HIGH = 3'b010,
    RATE_SYNC = 3'b100
  } rate_mode_t;
endpackage : baud_gen_pkg

// [bit_rate_timer.sv]
`timescale 1ns/10ps
// Free-running reloadable down-counter issuing one tick at terminal count
module bit_rate_timer #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Control
  input wire logic restart,
  input wire logic [WIDTH-1:0] period,
  // Result
  output logic tick,
  output logic [WIDTH-1:0] count
);
  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;
  logic tick_reg;
  wire atTerminal = (count_reg == '0);

  initial begin
    if (WIDTH < 1) $error("bit_rate_timer WIDTH must be positive");
  end

  // Reload on terminal count or restart, else count down
  assign count_next = (restart || atTerminal) ? period : count_reg - 1'b1;

  // Counter state
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      tick_reg <= atTerminal && !restart;
    end
  end

  assign tick = tick_reg;
  assign count = count_reg;
endmodule : bit_rate_timer

// [serial_baud_rate_generator.sv]
`timescale 1ns/10ps
`include "baud_gen_defs.svh"
//
// Function
// - One 8-bit timer serves both asynchronous and synchronous operation.
// - Timer runs freely; its period is set by the divisor register.
// - Async rate is clock over 64(n+1), or 16(n+1) with high speed.
// - Sync mode ignores high speed; rate is clock over 4(n+1).
// - Any divisor write reloads the timer with the written value at once.
// - Every reset clears the divisor register to zero.
//
// Register map, one 32-bit word each, bits [31:8] read zero in all but the status word
//   0x000 receive control: bit 7 enables the port
//   0x004 baud divisor n: the timer period is n+1 clocks
//   0x008 transmit control: bit 4 sync, bit 2 high speed, bit 3 reads zero
//   0x00c status, read only: [14:8] prescale count, [7:0] timer count
//
// Reset values
//   Receive control 0x00, divisor 0x00, transmit control 0x02
//   Timer, prescale and every output start at zero
//
// Bit period in clocks
//   Async, normal speed: 64 * (n + 1)
//   Async, high speed: 16 * (n + 1)
//   Sync, either speed: 4 * (n + 1)
//
// Bus timing
//   One wait state: pready rises the cycle after the first access edge
//   Read data and pslverr stand with pready for that one cycle only
//   Unmapped offsets answer with pslverr; their writes are dropped
//
// Outputs
//   bitRateTick pulses one clock per bit period
//   timerTick is the same pulse, kept for the clock logic
//   syncMode and portEnable are registered copies of control bits
//
// Hazards
//   A divisor write reloads the timer with the new value, not the old one
//   A mode change mid-period wraps the prescale at the new limit, at the next timer tick if already past it
//   The sync level output trails the control bit by one clock
//
module serial_baud_rate_generator (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Rate outputs
  output logic bitRateTick,
  output logic timerTick,
  output logic syncMode,
  output logic portEnable
);
  ////////////////////////////////////////////////////////////////////////
  logic [7:0] receiveStatusControl_reg;
  logic [7:0] baudDivisor_reg;
  logic [7:0] transmitStatusControl_reg;
  logic [6:0] prescale_reg;
  logic [6:0] prescale_next;
  logic bitRateTick_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic syncMode_reg;
  logic portEnable_reg;
  baud_gen_pkg::rate_mode_t rateMode;
  logic [6:0] prescaleLimit;
  logic rawTick;
  logic [7:0] timerCount;

  // Elaboration checks on the prescale counts
  initial begin
    if (`PRESCALE_ASYNC_LOW > 7'h40) $error("async prescale exceeds the 7-bit counter");
    if (`PRESCALE_SYNC < 7'h2) $error("sync prescale too short");
    if (`PRESCALE_ASYNC_HIGH < `PRESCALE_SYNC) $error("high speed prescale below sync");
  end

  // Bus decode
  wire access = psel && penable && !pready_reg;
  wire hitRcsc = (paddr == `ADDR_RECEIVE_STATUS_CONTROL);
  wire hitDiv = (paddr == `ADDR_BAUD_DIVISOR);
  wire hitTxsc = (paddr == `ADDR_TRANSMIT_STATUS_CONTROL);
  wire hitStat = (paddr == `ADDR_GEN_STATUS);
  wire mapped = hitRcsc || hitDiv || hitTxsc || hitStat;
  wire wrDiv = access && pwrite && hitDiv;
  wire wrRcsc = access && pwrite && hitRcsc;
  wire wrTxsc = access && pwrite && hitTxsc;

  // Read words, upper bits zero
  wire [31:0] wordRcsc = {24'h0, receiveStatusControl_reg};
  wire [31:0] wordDiv = {24'h0, baudDivisor_reg};
  wire [31:0] wordTxsc = {24'h0, transmitStatusControl_reg};
  wire [31:0] wordStat = {17'h0, prescale_reg, timerCount};
  wire [31:0] readMux = hitRcsc ? wordRcsc :
                        hitDiv ? wordDiv :
                        hitTxsc ? wordTxsc :
                        hitStat ? wordStat :
                        32'h0;

  // Mode selection; sync overrides high-speed
  wire syncBit = transmitStatusControl_reg[`TXSC_SYNC_BIT];
  wire highBit = transmitStatusControl_reg[`TXSC_HIGH_SPEED_BIT];
  assign rateMode = syncBit ? baud_gen_pkg::RATE_SYNC :
                    highBit ? baud_gen_pkg::RATE_ASYNC_HIGH : baud_gen_pkg::RATE_ASYNC_LOW;

  // Sub-tick count for the chosen mode
  always_comb begin
    case (rateMode)
      baud_gen_pkg::RATE_ASYNC_LOW: prescaleLimit = `PRESCALE_ASYNC_LOW;
      baud_gen_pkg::RATE_ASYNC_HIGH: prescaleLimit = `PRESCALE_ASYNC_HIGH;
      baud_gen_pkg::RATE_SYNC: prescaleLimit = `PRESCALE_SYNC;
      default: prescaleLimit = `PRESCALE_ASYNC_LOW;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Reload value; a divisor write must load the incoming value at once
  wire [7:0] reloadValue = wrDiv ? pwdata[7:0] : baudDivisor_reg;

  // Shared 8-bit timer, restarted by divisor writes
  bit_rate_timer #(
    .WIDTH(8)
  ) u_timer (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .restart(wrDiv),
    .period(reloadValue),
    .tick(rawTick),
    .count(timerCount)
  );

  // Prescale counts timer ticks; cleared with the timer
  wire prescaleWrap = rawTick && (prescale_reg >= prescaleLimit - 7'h1);
  assign prescale_next = (wrDiv || prescaleWrap) ? 7'h0 :
                         rawTick ? prescale_reg + 7'h1 : prescale_reg;

  ////////////////////////////////////////////////////////////////////////
  // Registers; reset clears divisor
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      baudDivisor_reg <= `RESET_BAUD_DIVISOR;
      receiveStatusControl_reg <= `RESET_RECEIVE_STATUS_CONTROL;
      transmitStatusControl_reg <= `RESET_TRANSMIT_STATUS_CONTROL;
    end else begin
      if (wrDiv) baudDivisor_reg <= pwdata[7:0];
      if (wrRcsc) receiveStatusControl_reg <= pwdata[7:0];
      if (wrTxsc) transmitStatusControl_reg <= pwdata[7:0] & `MASK_TRANSMIT_STATUS_CONTROL;
    end
  end

  // Rate tick and prescale
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prescale_reg <= 7'h0;
      bitRateTick_reg <= 1'b0;
      syncMode_reg <= 1'b0;
      portEnable_reg <= 1'b0;
    end else begin
      prescale_reg <= prescale_next;
      bitRateTick_reg <= prescaleWrap && !wrDiv;
      syncMode_reg <= syncBit;
      portEnable_reg <= receiveStatusControl_reg[`RCSC_ENABLE_BIT];
    end
  end

  // APB answer, one wait state
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0;
    end else begin
      pready_reg <= access;
      pslverr_reg <= access && !mapped;
      prdata_reg <= (access && !pwrite) ? readMux : 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs, each straight from a flip-flop
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign bitRateTick = bitRateTick_reg;
  assign timerTick = bitRateTick_reg;
  assign syncMode = syncMode_reg;
  assign portEnable = portEnable_reg;
endmodule : serial_baud_rate_generator

// [baud_gen_chk.sv]
`timescale 1ns/10ps
// Port-level checks of the bit-rate generator
module baud_gen_chk (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Rate outputs
  input wire logic bitRateTick,
  input wire logic timerTick,
  input wire logic syncMode,
  input wire logic portEnable
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Divisor write in its first access cycle
  sequence sDivWrite;
    psel && penable && pwrite && !pready && paddr == 12'h004;
  endsequence
  a_tick_alias: assert property (timerTick == bitRateTick) else $error("alias differs");
  a_tick_single: assert property (bitRateTick |=> !bitRateTick) else $error("tick too long");
  a_sync_min: assert property (bitRateTick && syncMode |=> !bitRateTick [*3]) else $error("tick gap");
  a_div_restart: assert property (sDivWrite |=> !bitRateTick [*2]) else $error("no restart");
  a_reset_quiet: assert property ($rose(rst_n) |-> !bitRateTick && !syncMode && !portEnable)
    else $error("reset outputs");
  a_one_wait: assert property (psel && penable && !pready |=> pready ##1 !pready) else $error("wait state");
  a_bus_idle: assert property (!(psel && penable) |=> !pready) else $error("spurious ready");
  a_err_map: assert property (pready |-> pslverr == !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00c}))
    else $error("slave error");
  a_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h000000) else $error("upper bits");
endmodule : baud_gen_chk

// [serial_baud_rate_generator_tb.sv]
`timescale 1ns/10ps
module serial_baud_rate_generator_tb;
  logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, bitRateTick, timerTick, syncMode, portEnable;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic err;
  int bad_count, checked, gap, i;
  logic [7:0] modeTab [4] = '{8'h00, 8'h04, 8'h10, 8'h14};
  int scaleTab [4] = '{64, 16, 4, 4};
  serial_baud_rate_generator i_dut (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .bitRateTick(bitRateTick),
    .timerTick(timerTick),
    .syncMode(syncMode),
    .portEnable(portEnable)
  );
  ////////////////////////////////////////////////////////////
  // Clock
  initial begin
    clk_sys = 0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // One APB transfer, held until ready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    begin
      @(posedge clk_sys);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk_sys);
      penable <= 1;
      k = 0;
      do @(posedge clk_sys); while (pready !== 1'b1 && ++k < 50);
      if (pready !== 1'b1) bad_count++;
      rd = prdata;
      err = pslverr;
      psel <= 0; penable <= 0;
    end
  endtask : apb
  task cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
    begin
      checked++;
      if (got !== exp) begin
        bad_count++;
        $display("BAD %s expected %h seen %h", name, exp, got);
      end
    end
  endtask : cmp
  // Cycles from now to next tick (first) and on to the one after (gap)
  task period(output int first, output int n);
    begin
      first = 0;
      do begin @(posedge clk_sys); #1; first++; end while (bitRateTick !== 1'b1 && first < 900);
      n = 0;
      do begin @(posedge clk_sys); #1; n++; end while (bitRateTick !== 1'b1 && n < 900);
    end
  endtask : period
  task conclude;
    begin
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask : conclude
  // Watchdog: tests take under a thousand cycles, allow 40000
  initial begin
    #200000;
    bad_count++;
    conclude();
  end
  ////////////////////////////////////////////////////////////
  // Tests
  initial begin
    rst_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1;
    apb(0, 12'h000, 0); cmp("rx ctrl", 32'h0, rd);
    apb(0, 12'h004, 0); cmp("divisor", 32'h0, rd);
    apb(0, 12'h008, 0); cmp("tx ctrl", 32'h2, rd);
    apb(0, 12'h010, 0); cmp("unmapped", 32'h1, {31'h0, err});
    period(i, gap); cmp("period n0", 64, gap);
    apb(1, 12'h004, 32'h2); apb(0, 12'h004, 0); cmp("div rd", 32'h2, rd);
    for (i = 0; i < 4; i++) begin
      apb(1, 12'h008, {24'h0, modeTab[i]});
      period(gap, gap); cmp("period", scaleTab[i] * 3, gap);
    end
    apb(1, 12'h008, 32'hff); apb(0, 12'h008, 0); cmp("tx mask", 32'hf7, rd);
    #1 cmp("sync level", 1, syncMode);
    // Divisor 5 in sync mode: period 24; rewrite mid-period must restart
    apb(1, 12'h004, 32'h5);
    period(i, gap);
    repeat (8) @(posedge clk_sys);
    apb(1, 12'h004, 32'h5);
    period(gap, i); cmp("restart", 1, gap > 14);
    apb(1, 12'h000, 32'h80); #1 cmp("enable", 1, portEnable);
    // Mid-run reset must clear the divisor again
    @(posedge clk_sys);
    rst_n <= 0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1;
    apb(0, 12'h004, 0); cmp("div after reset", 32'h0, rd);
    #1 cmp("enable after reset", 0, portEnable);
    conclude();
  end
endmodule : serial_baud_rate_generator_tb
bind serial_baud_rate_generator baud_gen_chk i_chk (
  .clk_sys(clk_sys),
  .rst_n(rst_n),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .bitRateTick(bitRateTick),
  .timerTick(timerTick),
  .syncMode(syncMode),
  .portEnable(portEnable)
);
